// >>> hw/ati_core.sv
// Ambient light sensor command port, conversion sequencer and interrupt pin
// What this block does
// - Start powered down after reset; no conversions until powered up.
// - Control value 0x03 keeps power on and runs both channel conversions.
// - Timing value 0xB6 gives a 200 ms integration cycle.
// - Word read with 0xB4 returns bytes at 0x14 then 0x15.
// - Channel 1 word read returns 0x16 low then 0x17 high.
// - Interrupt control 00h at 02h disables interrupts entirely.
// - Two 16-bit thresholds, lower and upper, bound the window.
// - Only channel 0 is compared; channel 1 never affects interrupts.
// - Persistence 1 fires on the first out-of-window conversion.
// - Persistence N of 2..15 needs N consecutive outside conversions.
// - Interrupt pin held low until the special clear command or a write to interrupt control.
// - Persistence 0000b fires at every conversion end, thresholds ignored.
// - At or below lower, or above upper, is outside; bytes pair.
`timescale 1ns/1ps
module ati_core
   import ati_pkg::*;
#(
   parameter int STEP_CYCLES = ATI_STEP_CYCLES,
   parameter logic [7:0] ID_VALUE = 8'hA5      // Arbitrary identification value
)
(
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        host_wr_stb,
   input  wire logic        host_wr_cmd,
   input  wire logic [7:0]  host_wr_byte,
   input  wire logic        host_rd_stb,
   output logic [7:0]       host_rd_byte,
   input  wire logic [15:0] adc_ch0,
   input  wire logic [15:0] adc_ch1,
   output logic             int_out,
   output logic             int_oe,
   output logic             powered,
   output logic             converting,
   output logic             conv_done
);

   localparam int SW = $clog2(STEP_CYCLES + 1);
   localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_r;
   logic [7:0]  timing_r;
   logic [7:0]  intctl_r;
   logic [15:0] thr_lo_r;
   logic [15:0] thr_hi_r;
   logic [15:0] data0_r;
   logic [15:0] data1_r;
   logic [7:0]  shadow_r;
   logic [4:0]  ptr_r;
   logic        word_r;
   logic [7:0]  rd_byte_r;
   logic        int_clr;
   logic        persist_wr;
   logic        irq;
   logic [3:0]  pcnt;
   ati_xfer_t   xfer;
   ati_state_t  state_r;
   logic [SW-1:0] step_cnt_r;
   logic [8:0]  icnt_r;
   logic [8:0]  icnt_target;
   logic        step_tick;
   logic        done_r;
   logic        data_wr;
   logic        cmd_wr;

   assign cmd_wr  = host_wr_stb && host_wr_cmd && host_wr_byte[ATI_CMD_BIT];
   assign data_wr = host_wr_stb && !host_wr_cmd;
   assign xfer    = ati_xfer_t'(host_wr_byte[ATI_CMD_TYPE_HI:ATI_CMD_TYPE_LO]);

   // ----------------------------------------------------------------
   // Command byte decode
   // ----------------------------------------------------------------
   // a command byte other than a special function one loads the address pointer and transfer kind
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ptr_r  <= ATI_ADDR_CTRL;
         word_r <= 1'b0;
      end else if (cmd_wr && xfer != ATI_TR_SPECIAL) begin
         ptr_r  <= host_wr_byte[ATI_CMD_ADDR_HI:0];
         word_r <= (xfer == ATI_TR_WORD);
      end else if ((data_wr || host_rd_stb) && word_r) begin
         // word transfers step to the paired register
         ptr_r  <= ptr_r + 5'h01;
      end
   end

   // special function command releases the interrupt
   assign int_clr = cmd_wr && xfer == ATI_TR_SPECIAL &&
                    host_wr_byte[ATI_CMD_ADDR_HI:0] == ATI_SF_INT_CLEAR;
   assign persist_wr = data_wr && ptr_r == ATI_ADDR_INTCTL;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // everything starts powered down with all zero settings
   // thresholds assembled from separately written bytes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r   <= ATI_CTRL_RESET;
         timing_r <= ATI_TIMING_RESET;
         intctl_r <= ATI_INTCTL_RESET;
         thr_lo_r <= {ATI_THR_RESET, ATI_THR_RESET};
         thr_hi_r <= {ATI_THR_RESET, ATI_THR_RESET};
      end else if (data_wr) begin
         case (ptr_r)
            ATI_ADDR_CTRL:   ctrl_r         <= host_wr_byte;
            ATI_ADDR_TIMING: timing_r       <= host_wr_byte;
            ATI_ADDR_INTCTL: intctl_r       <= host_wr_byte;
            ATI_ADDR_TLO_L:  thr_lo_r[7:0]  <= host_wr_byte;
            ATI_ADDR_TLO_H:  thr_lo_r[15:8] <= host_wr_byte;
            ATI_ADDR_THI_L:  thr_hi_r[7:0]  <= host_wr_byte;
            ATI_ADDR_THI_H:  thr_hi_r[15:8] <= host_wr_byte;
            default: ;                        // Read-only or unmapped
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // low byte read freezes the high byte, so a conversion
   // finishing between the two reads cannot tear the word
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_byte_r <= ATI_READ_ZERO;
         shadow_r  <= ATI_DATA_RESET;
      end else if (host_rd_stb) begin
         case (ptr_r)
            ATI_ADDR_CTRL:   rd_byte_r <= ctrl_r;
            ATI_ADDR_TIMING: rd_byte_r <= timing_r;
            ATI_ADDR_INTCTL: rd_byte_r <= intctl_r;
            ATI_ADDR_TLO_L:  rd_byte_r <= thr_lo_r[7:0];
            ATI_ADDR_TLO_H:  rd_byte_r <= thr_lo_r[15:8];
            ATI_ADDR_THI_L:  rd_byte_r <= thr_hi_r[7:0];
            ATI_ADDR_THI_H:  rd_byte_r <= thr_hi_r[15:8];
            ATI_ADDR_ID:     rd_byte_r <= ID_VALUE;
            ATI_ADDR_D0L: begin
               rd_byte_r <= data0_r[7:0];
               shadow_r  <= data0_r[15:8];
            end
            ATI_ADDR_D1L: begin
               rd_byte_r <= data1_r[7:0];
               shadow_r  <= data1_r[15:8];
            end
            ATI_ADDR_D0H,
            ATI_ADDR_D1H:    rd_byte_r <= shadow_r;
            default:         rd_byte_r <= ATI_READ_ZERO;
         endcase
      end
   end

   assign host_rd_byte = rd_byte_r;

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   // power bit and converter enable pick the state
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ATI_ST_OFF;
      end else begin
         case (state_r)
            ATI_ST_OFF: begin
               if (ctrl_r[ATI_CTRL_POWER_BIT]) begin
                  state_r <= ATI_ST_IDLE;
               end
            end
            ATI_ST_IDLE: begin
               if (!ctrl_r[ATI_CTRL_POWER_BIT]) begin
                  state_r <= ATI_ST_OFF;
               end else if (ctrl_r[ATI_CTRL_ADC_BIT]) begin
                  state_r <= ATI_ST_INTEG;
               end
            end
            ATI_ST_INTEG: begin
               if (!ctrl_r[ATI_CTRL_POWER_BIT]) begin
                  state_r <= ATI_ST_OFF;
               end else if (!ctrl_r[ATI_CTRL_ADC_BIT]) begin
                  state_r <= ATI_ST_IDLE;
               end
            end
            default: state_r <= ATI_ST_OFF;
         endcase
      end
   end

   // Step divider: one enable pulse per integration step
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         step_cnt_r <= '0;
      end else if (state_r != ATI_ST_INTEG || step_tick) begin
         step_cnt_r <= '0;
      end else begin
         step_cnt_r <= step_cnt_r + SW'(1);
      end
   end

   assign step_tick = (state_r == ATI_ST_INTEG) && (step_cnt_r == STEP_LAST);

   // cycle length is 256 minus the timing value in steps
   // Timing changes take effect from the next step, not a fresh cycle
   assign icnt_target = ATI_INTEG_FULL - {1'b0, timing_r};

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         icnt_r <= 9'h000;
      end else if (state_r != ATI_ST_INTEG) begin
         icnt_r <= 9'h000;
      end else if (step_tick) begin
         icnt_r <= (icnt_r + 9'h001 >= icnt_target) ? 9'h000 : icnt_r + 9'h001;
      end
   end

   // end of cycle moves results into the data registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         done_r  <= 1'b0;
         data0_r <= {ATI_DATA_RESET, ATI_DATA_RESET};
         data1_r <= {ATI_DATA_RESET, ATI_DATA_RESET};
      end else begin
         done_r <= step_tick && (icnt_r + 9'h001 >= icnt_target);
         if (step_tick && (icnt_r + 9'h001 >= icnt_target)) begin
            data0_r <= adc_ch0;
            data1_r <= adc_ch1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt decision
   // ----------------------------------------------------------------
   // evaluate channel 0 only; mode 00 disables and clears
   ati_persist u_persist (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .eval    (done_r),
      .ch0     (data0_r),
      .thr_lo  (thr_lo_r),
      .thr_hi  (thr_hi_r),
      .persist (intctl_r[ATI_PERSIST_HI:0]),
      .enable  (intctl_r[ATI_MODE_HI:ATI_MODE_LO] != ATI_MODE_DISABLED),
      .clr     (int_clr || persist_wr ||
                intctl_r[ATI_MODE_HI:ATI_MODE_LO] == ATI_MODE_DISABLED),
      .irq_r   (irq),
      .cnt_r   (pcnt)
   );

   // open-drain pin pulled low while the flag stands
   assign int_out    = 1'b0;
   assign int_oe     = irq;
   assign powered    = state_r != ATI_ST_OFF;
   assign converting = state_r == ATI_ST_INTEG;
   assign conv_done  = done_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_no_conv_off;
      state_r == ATI_ST_OFF |-> !step_tick ##1 !done_r;
   endproperty
   a_no_conv_off: assert property (p_no_conv_off) else $error("conversion while powered down");

   property p_run_03;
      data_wr && ptr_r == ATI_ADDR_CTRL && host_wr_byte == 8'h03 ##1 !data_wr |=> converting;
   endproperty
   a_run_03: assert property (p_run_03) else $error("0x03 did not start conversions");

   property p_transfer;
      step_tick && (icnt_r + 9'h001 >= icnt_target) |=> done_r && data0_r == $past(adc_ch0)
         && data1_r == $past(adc_ch1);
   endproperty
   a_transfer: assert property (p_transfer) else $error("results not transferred");

   property p_steps_b6;
      timing_r == ATI_REF_TIMING |-> icnt_target == 9'h04A;
   endproperty
   a_steps_b6: assert property (p_steps_b6) else $error("0xB6 not 74 steps");

   property p_pin;
      int_oe == irq && !int_out;
   endproperty
   a_pin: assert property (p_pin) else $error("pin does not follow flag");

   property p_clear;
      int_clr && !done_r |=> !int_oe;
   endproperty
   a_clear: assert property (p_clear) else $error("clear command ignored");

   property p_shadow;
      host_rd_stb && ptr_r == ATI_ADDR_D0L ##2 host_rd_stb && ptr_r == ATI_ADDR_D0H
         |=> host_rd_byte == $past(data0_r[15:8], 3);
   endproperty
   a_shadow: assert property (p_shadow) else $error("high byte not paired");

   property p_disabled;
      intctl_r == 8'h00 |=> !int_oe;
   endproperty
   a_disabled: assert property (p_disabled) else $error("interrupt while disabled");

endmodule

// >>> hw/ati_pkg.sv
// Shared constants for the ambient light threshold interrupt block
package ati_pkg;

   // ----------------------------------------------------------------
   // Register addresses (5-bit address field of the command byte)
   // ----------------------------------------------------------------
   localparam logic [4:0] ATI_ADDR_CTRL   = 5'h00;
   localparam logic [4:0] ATI_ADDR_TIMING = 5'h01;
   localparam logic [4:0] ATI_ADDR_INTCTL = 5'h02;
   localparam logic [4:0] ATI_ADDR_TLO_L  = 5'h03;
   localparam logic [4:0] ATI_ADDR_TLO_H  = 5'h04;
   localparam logic [4:0] ATI_ADDR_THI_L  = 5'h05;
   localparam logic [4:0] ATI_ADDR_THI_H  = 5'h06;
   localparam logic [4:0] ATI_ADDR_ID     = 5'h12;
   localparam logic [4:0] ATI_ADDR_D0L    = 5'h14;
   localparam logic [4:0] ATI_ADDR_D0H    = 5'h15;
   localparam logic [4:0] ATI_ADDR_D1L    = 5'h16;
   localparam logic [4:0] ATI_ADDR_D1H    = 5'h17;

   // ----------------------------------------------------------------
   // Command byte layout
   // ----------------------------------------------------------------
   localparam int         ATI_CMD_BIT      = 7;
   localparam int         ATI_CMD_TYPE_HI  = 6;
   localparam int         ATI_CMD_TYPE_LO  = 5;
   localparam int         ATI_CMD_ADDR_HI  = 4;
   localparam logic [4:0] ATI_SF_INT_CLEAR = 5'h01;

   typedef enum logic [1:0] {
      ATI_TR_BYTE    = 2'b00,
      ATI_TR_WORD    = 2'b01,
      ATI_TR_RSVD    = 2'b10,
      ATI_TR_SPECIAL = 2'b11
   } ati_xfer_t;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         ATI_CTRL_POWER_BIT = 0;
   localparam int         ATI_CTRL_ADC_BIT   = 1;
   localparam int         ATI_MODE_HI        = 5;
   localparam int         ATI_MODE_LO        = 4;
   localparam int         ATI_PERSIST_HI     = 3;
   localparam logic [1:0] ATI_MODE_DISABLED  = 2'b00;
   localparam logic [7:0] ATI_CTRL_RESET     = 8'h00;
   localparam logic [7:0] ATI_TIMING_RESET   = 8'h00;
   localparam logic [7:0] ATI_INTCTL_RESET   = 8'h00;
   localparam logic [7:0] ATI_THR_RESET      = 8'h00;
   localparam logic [7:0] ATI_DATA_RESET     = 8'h00;
   localparam logic [7:0] ATI_READ_ZERO      = 8'h00;

   // ----------------------------------------------------------------
   // Timing: reference setting of 0xB6 gives a 200 ms cycle
   // ----------------------------------------------------------------
   localparam int         ATI_CLK_PERIOD_NS = 40;
   localparam int         ATI_NS_PER_MS     = 1000000;
   localparam logic [7:0] ATI_REF_TIMING    = 8'hB6;
   localparam int         ATI_REF_CONV_MS   = 200;
   localparam logic [8:0] ATI_INTEG_FULL    = 9'h100;
   localparam int         ATI_REF_STEPS     = 256 - 8'hB6;
   localparam int         ATI_STEP_CYCLES   =
      (ATI_REF_CONV_MS * ATI_NS_PER_MS / ATI_CLK_PERIOD_NS) / ATI_REF_STEPS;

   // Sequencer states
   typedef enum logic [2:0] {
      ATI_ST_OFF   = 3'b001,
      ATI_ST_IDLE  = 3'b010,
      ATI_ST_INTEG = 3'b100
   } ati_state_t;

endpackage

// >>> hw/ati_persist.sv
// Threshold window compare and persistence filter driving the interrupt flag
`timescale 1ns/1ps
module ati_persist
   import ati_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        eval,
   input  wire logic [15:0] ch0,
   input  wire logic [15:0] thr_lo,
   input  wire logic [15:0] thr_hi,
   input  wire logic [3:0]  persist,
   input  wire logic        enable,
   input  wire logic        clr,
   output logic             irq_r,
   output logic [3:0]       cnt_r
);

   // ----------------------------------------------------------------
   // Window compare
   // ----------------------------------------------------------------
   logic       outside;
   logic [4:0] cnt_base;
   logic [4:0] cnt_inc;
   logic       hit;

   // low edge inclusive, high edge exclusive
   assign outside  = (ch0 <= thr_lo) || (ch0 > thr_hi);
   assign cnt_base = clr ? 5'h00 : {1'b0, cnt_r};
   assign cnt_inc  = cnt_base + 5'h01;

   always_comb begin
      if (!enable) begin
         hit = 1'b0;
      end else if (persist == 4'h0) begin
         hit = 1'b1;
      end else begin
         hit = outside && (cnt_inc >= {1'b0, persist});
      end
   end

   // counter restarts on inside, clear or persistence rewrite
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 4'h0;
      end else if (eval && enable) begin
         if (outside && cnt_inc <= 5'h0F) begin
            cnt_r <= cnt_inc[3:0];
         end else if (!outside) begin
            cnt_r <= 4'h0;
         end else begin
            cnt_r <= 4'hF;                   // Saturate, no wrap
         end
      end else if (clr) begin
         cnt_r <= 4'h0;
      end
   end

   // sticky flag; a firing conversion beats a same-cycle clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_r <= 1'b0;
      end else if (eval && hit) begin
         irq_r <= 1'b1;
      end else if (clr) begin
         irq_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_first_out;
      eval && enable && persist == 4'h1 && outside |=> irq_r;
   endproperty
   a_first_out: assert property (p_first_out) else $error("persist 1 did not fire");

   property p_nth_out;
      eval && enable && !clr && outside && persist >= 4'h2 && ({1'b0, cnt_r} + 5'h01) == {1'b0, persist}
         |=> irq_r;
   endproperty
   a_nth_out: assert property (p_nth_out) else $error("persist N did not fire");

   property p_early;
      eval && enable && !irq_r && !clr && persist >= 4'h2 && cnt_r == 4'h0 |=> !irq_r;
   endproperty
   a_early: assert property (p_early) else $error("fired before N conversions");

   property p_eoc;
      eval && enable && persist == 4'h0 |=> irq_r;
   endproperty
   a_eoc: assert property (p_eoc) else $error("end of conversion did not fire");

   property p_hold;
      irq_r && !clr |=> irq_r;
   endproperty
   a_hold: assert property (p_hold) else $error("interrupt dropped without clear");

   property p_inside;
      eval && enable && !outside && !clr && persist != 4'h0 && !irq_r |=> !irq_r && cnt_r == 4'h0;
   endproperty
   a_inside: assert property (p_inside) else $error("inside window counted");

   property p_cnt_clr;
      clr && !eval |=> cnt_r == 4'h0;
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("counter not reset");

endmodule

// >>> tb/ati_host_model.sv
// Host controller model driving the sensor command, data and read strobes
`timescale 1ns/1ps
module ati_host_model (
   input  wire logic       sys_clk,
   output logic            host_wr_stb,
   output logic            host_wr_cmd,
   output logic [7:0]      host_wr_byte,
   output logic            host_rd_stb,
   input  wire logic [7:0] host_rd_byte
);
   // ------------
   // Idle levels
   // ------------
   initial begin
      host_wr_stb  = 1'b0;
      host_wr_cmd  = 1'b0;
      host_wr_byte = 8'h00;
      host_rd_stb  = 1'b0;
   end

   // command byte marking
   // Released data is inverted so a stale byte never looks valid
   task automatic wr(input logic cmd, input logic [7:0] b);
      @(posedge sys_clk);
      host_wr_stb  <= 1'b1;
      host_wr_cmd  <= cmd;
      host_wr_byte <= b;
      @(posedge sys_clk);
      host_wr_stb  <= 1'b0;
      host_wr_cmd  <= 1'b0;
      host_wr_byte <= ~b;
   endtask

   task automatic write_reg(input logic [7:0] cmd, input logic [7:0] d);
      wr(1'b1, cmd);
      wr(1'b0, d);
   endtask

   // Read byte lands on the same clock edge that takes the strobe
   task automatic rd(output logic [7:0] d);
      @(posedge sys_clk);
      host_rd_stb <= 1'b1;
      @(posedge sys_clk);
      host_rd_stb <= 1'b0;
      #1;
      d = host_rd_byte;
   endtask

   task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
      logic [7:0] lo;
      logic [7:0] hi;
      wr(1'b1, cmd);
      rd(lo);
      rd(hi);
      w = 16'(hi) * 16'h0100 + 16'(lo);
   endtask
endmodule

// >>> tb/als_threshold_interrupt_ctrl_tb_top.sv
// Self-checking bench for the light sensor threshold interrupt core
`timescale 1ns/1ps
module als_threshold_interrupt_ctrl_tb_top;
   import ati_pkg::*;
   localparam int STEP = 4;   // Short step keeps conversions to a few hundred cycles
   logic        sys_clk;
   logic        resetn;
   logic        host_wr_stb;
   logic        host_wr_cmd;
   logic [7:0]  host_wr_byte;
   logic        host_rd_stb;
   logic [7:0]  host_rd_byte;
   logic [15:0] adc_ch0;
   logic [15:0] adc_ch1;
   logic        int_out;
   logic        int_oe;
   logic        powered;
   logic        converting;
   logic        conv_done;
   logic        seen_act;
   logic [15:0] w;
   int          errors;
   int          checks;
   int          c;
   // Persistence values covering both ends of the range
   int          c_tab [3] = '{2, 3, 15};

   ati_core #(.STEP_CYCLES(STEP)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .host_wr_stb(host_wr_stb),
      .host_wr_cmd(host_wr_cmd), .host_wr_byte(host_wr_byte), .host_rd_stb(host_rd_stb),
      .host_rd_byte(host_rd_byte), .adc_ch0(adc_ch0), .adc_ch1(adc_ch1), .int_out(int_out),
      .int_oe(int_oe), .powered(powered), .converting(converting), .conv_done(conv_done));
   ati_host_model u_host (.sys_clk(sys_clk), .host_wr_stb(host_wr_stb), .host_wr_cmd(host_wr_cmd),
      .host_wr_byte(host_wr_byte), .host_rd_stb(host_rd_stb), .host_rd_byte(host_rd_byte));

   // Free-running 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   // ------------
   // Helpers
   // ------------
   task automatic end_of_test;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // Bounded wait for n conversion pulses; cyc holds the length of the last one
   task automatic wait_conv(input int n, output int cyc);
      for (int i = 0; i < n; i++) begin
         cyc = 0;
         do begin
            @(posedge sys_clk);
            #1;
            cyc++;
         end while (conv_done !== 1'b1 && cyc < 1000);
         if (cyc >= 1000) begin
            errors++;
            $display("CHECK FAILED t=%0t conversion never ended", $time);
            end_of_test();
         end
      end
   endtask

   // Interrupt pin is judged the cycle after the last pulse
   task automatic irq_after(input int n, input logic exp, input string msg);
      int k;
      wait_conv(n, k);
      @(posedge sys_clk);
      #1;
      chk(16'(int_oe), 16'(exp), msg);
   endtask

   task automatic set_ch0(input logic [15:0] v);
      @(posedge sys_clk);
      adc_ch0 <= v;
   endtask

   // Reconfigure just after a conversion so the next one sees the new setup
   task automatic cfg(input logic [7:0] ictl, input logic [15:0] v);
      int k;
      wait_conv(1, k);
      set_ch0(v);
      u_host.write_reg(8'h82, ictl);
   endtask

   task automatic clear_irq;
      u_host.wr(1'b1, 8'hE1);
      @(posedge sys_clk);
      #1;
   endtask

   // ------------
   // Main sequence
   // ------------
   initial begin
      sys_clk  = 1'b0;
      resetn   = 1'b0;
      adc_ch0  = 16'h1234;
      adc_ch1  = 16'hABCD;
      errors   = 0;
      checks   = 0;
      seen_act = 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         #1;
         seen_act = seen_act | conv_done | converting | powered;
      end
      chk(16'(seen_act), 16'h0000, "active before power up");
      chk(16'(host_rd_byte), 16'h0000, "read byte after reset");
      u_host.write_reg(8'h80, 8'h01);
      @(posedge sys_clk);
      #1;
      chk(16'({powered, converting}), 16'h0002, "power up only");
      u_host.write_reg(8'h81, 8'hB6);
      u_host.write_reg(8'h80, 8'h03);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(16'({powered, converting}), 16'h0003, "converter enable");
      wait_conv(2, c);
      chk(16'(c), 16'(74 * STEP), "integration cycle length");
      set_ch0(16'h5555);
      u_host.read_word(8'hB4, w);
      chk(w, 16'h1234, "channel 0 word");
      u_host.read_word(8'hB6, w);
      chk(w, 16'hABCD, "channel 1 word");
      // Short cycles and a 0100h..0200h window for the interrupt part
      @(posedge sys_clk);
      adc_ch1 <= 16'h0000;
      u_host.write_reg(8'h81, 8'hF8);
      u_host.write_reg(8'hA3, 8'h00);
      u_host.wr(1'b0, 8'h01);
      u_host.write_reg(8'hA5, 8'h00);
      u_host.wr(1'b0, 8'h02);
      cfg(8'h00, 16'h0000);
      irq_after(3, 1'b0, "disabled mode");
      cfg(8'h11, 16'h0100);
      irq_after(1, 1'b1, "equal to lower bound");
      chk(16'(int_out), 16'h0000, "pin drives low");
      set_ch0(16'h0150);
      irq_after(2, 1'b1, "held until cleared");
      clear_irq();
      chk(16'(int_oe), 16'h0000, "special clear");
      irq_after(2, 1'b0, "inside window");
      cfg(8'h11, 16'h0200);
      irq_after(2, 1'b0, "equal to upper bound");
      cfg(8'h11, 16'h0201);
      irq_after(1, 1'b1, "above upper bound");
      foreach (c_tab[j]) begin
         cfg(8'h10 | 8'(c_tab[j]), 16'h0000);
         irq_after(c_tab[j] - 1, 1'b0, "persistence not yet met");
         irq_after(1, 1'b1, "persistence met");
      end
      cfg(8'h13, 16'h0000);
      irq_after(2, 1'b0, "two outside");
      set_ch0(16'h0180);
      irq_after(1, 1'b0, "inside resets count");
      set_ch0(16'h0000);
      irq_after(2, 1'b0, "count restarted");
      irq_after(1, 1'b1, "third consecutive");
      clear_irq();
      irq_after(2, 1'b0, "clear resets count");
      irq_after(1, 1'b1, "count after clear");
      cfg(8'h10, 16'h0180);
      irq_after(1, 1'b1, "end of conversion mode");
      clear_irq();
      irq_after(1, 1'b1, "every conversion");
      end_of_test();
   end
endmodule
